// ==== rtl/flc_regs.sv ====
/*
  Control register bank and light sequencer of a two-channel flash LED
  driver. Holds the unlock key, channel enables, flash timing, current
  levels and protection thresholds, and turns requests into drive levels.
  Assumes a serial protocol engine on the same clock presents single-cycle
  write and read strobes with a 3-bit index; analogue detector levels and
  pins arrive asynchronously.
*/
`default_nettype none

module flc_regs #(
  parameter int CYCLES_PER_MS = flc_pkg::CYCLES_PER_MS
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic                                 reg_wr_en,
  input  wire logic                                 reg_rd_en,
  input  wire logic [flc_pkg::ADDR_W-1:0]           reg_addr,
  input  wire logic [flc_pkg::DATA_W-1:0]           reg_wdata,
  output logic      [flc_pkg::DATA_W-1:0]           reg_rdata,
  input  wire logic                                 strobe_pin,
  input  wire logic                                 torch_pin,
  input  wire logic                                 overheat_detect,
  input  wire logic                                 thermistor_low,
  input  wire logic                                 supply_low,
  output logic                                      channel_a_on,
  output logic                                      channel_b_on,
  output logic                                      flash_drive,
  output logic                                      torch_drive,
  output logic                                      core_powered,
  output logic                                      bank_unlocked,
  output logic                                      headroom_select,
  output logic      [flc_pkg::LEVEL_W-1:0]          flash_level_code,
  output logic      [flc_pkg::LEVEL_W-1:0]          torch_level_code,
  output logic                                      low_torch_scale,
  output logic      [flc_pkg::LIMIT_W-1:0]          coil_limit_code,
  output logic      [flc_pkg::THERM_W-1:0]          thermistor_threshold_code,
  output logic      [flc_pkg::SUPPLY_W-1:0]         supply_threshold_code
);

  logic [flc_pkg::DATA_W-1:0] ctl_reg [flc_pkg::NUM_REGS];
  logic                       unlocked;
  logic [4:0]                 pins_sync;
  logic                       strobe_s;
  logic                       torch_pin_s;
  logic                       overheat_s;
  logic                       therm_low_s;
  logic                       supply_low_s;
  logic                       flash_req;
  logic                       flash_req_reg;
  logic                       torch_req;
  logic                       flash_start;
  logic                       enabled;
  logic                       edge_mode;
  logic                       auto_recover;
  logic                       therm_trip;
  logic                       supply_trip;
  logic                       timer_expired;
  logic                       timer_run;
  flc_pkg::flc_state_e        state_reg;
  flc_pkg::flc_state_e        state_next;
  logic                       lit_next;
  logic                       flash_next;
  logic                       torch_next;
  logic                       powered_next;
  logic [flc_pkg::DATA_W-1:0] rdata_next;

  // Pins and analogue detector levels are asynchronous to the system clock.
  flc_sync #(
    .W (5)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({supply_low, thermistor_low, overheat_detect, torch_pin, strobe_pin}),
    .sync_out (pins_sync)
  );

  assign strobe_s     = pins_sync[0];
  assign torch_pin_s  = pins_sync[1];
  assign overheat_s   = pins_sync[2];
  assign therm_low_s  = pins_sync[3];
  assign supply_low_s = pins_sync[4];

  // The bank opens only while the key register holds the key.
  assign unlocked = (ctl_reg[flc_pkg::KEY_OFF] == flc_pkg::UNLOCK_KEY);

  // One register per index; the key register is always writable, the rest only when open.
  for (genvar g = 0; g < flc_pkg::NUM_REGS; g++) begin : g_reg
    logic wr_hit;
    assign wr_hit = reg_wr_en && (reg_addr == flc_pkg::ADDR_W'(g))
                    && (unlocked || (g == flc_pkg::KEY_OFF));
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ctl_reg[g] <= flc_pkg::REG_RESET[g];
      end else if (wr_hit) begin
        ctl_reg[g] <= reg_wdata & flc_pkg::REG_MASK[g];
      end
    end
  end

  // Indices past the light register are unmapped and read as zero; writes there hit nothing.
  assign rdata_next = (reg_addr >= flc_pkg::ADDR_W'(flc_pkg::NUM_REGS)) ? '0 :
                      (unlocked || reg_addr == flc_pkg::KEY_OFF) ? ctl_reg[reg_addr] : '0;

  // Field decode.
  assign enabled      = ctl_reg[flc_pkg::ENABLE_OFF][flc_pkg::ENA_A_BIT]
                        || ctl_reg[flc_pkg::ENABLE_OFF][flc_pkg::ENA_B_BIT];
  assign edge_mode    = ctl_reg[flc_pkg::TIMING_OFF][flc_pkg::EDGE_BIT];
  assign auto_recover = ctl_reg[flc_pkg::TIMING_OFF][flc_pkg::RECOVER_BIT];
  assign therm_trip   = (ctl_reg[flc_pkg::PROT_OFF][flc_pkg::THERM_LSB +: flc_pkg::THERM_W]
                         != '0) && therm_low_s;
  assign supply_trip  = (ctl_reg[flc_pkg::PROT_OFF][flc_pkg::SUPPLY_LSB +: flc_pkg::SUPPLY_W]
                         != '0) && supply_low_s;

  // The strobe pin and the flash bit both request flash; torch pin or bit request torch.
  assign flash_req   = ctl_reg[flc_pkg::LIGHT_OFF][flc_pkg::FLASH_BIT] || strobe_s;
  assign torch_req   = ctl_reg[flc_pkg::LIGHT_OFF][flc_pkg::TORCH_BIT] || torch_pin_s;
  // Edge control starts only on a fresh request, so a held request cannot relight.
  assign flash_start = edge_mode ? (flash_req && !flash_req_reg) : flash_req;

  // The timer runs only inside a flash and restarts from zero on the next one.
  assign timer_run = (state_reg == flc_pkg::ST_FLASH);

  flc_flash_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (timer_run),
    .dur_code (ctl_reg[flc_pkg::TIMING_OFF][flc_pkg::TIME_LSB +: flc_pkg::TIME_W]),
    .expired  (timer_expired)
  );

  // Overheating beats everything while a channel is enabled; power-down beats any request.
  always_comb begin
    state_next = state_reg;
    if (overheat_s && enabled) begin
      state_next = flc_pkg::ST_SHUTDOWN;
    end else if (state_reg == flc_pkg::ST_SHUTDOWN) begin
      if (!enabled || auto_recover) begin
        state_next = flc_pkg::ST_IDLE;
      end
    end else if (!enabled || therm_trip) begin
      state_next = flc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        flc_pkg::ST_IDLE, flc_pkg::ST_TORCH: begin
          if (flash_start) begin
            state_next = flc_pkg::ST_FLASH;
          end else if (torch_req) begin
            state_next = flc_pkg::ST_TORCH;
          end else begin
            state_next = flc_pkg::ST_IDLE;
          end
        end
        flc_pkg::ST_FLASH: begin
          if (timer_expired) begin
            state_next = flc_pkg::ST_SPENT;
          end else if (!edge_mode && !flash_req) begin
            state_next = flc_pkg::ST_IDLE;
          end
        end
        flc_pkg::ST_SPENT: begin
          if (!flash_req) begin
            state_next = flc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = flc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // A low supply turns a flash into torch current rather than cutting light.
  assign lit_next     = (state_next == flc_pkg::ST_FLASH) || (state_next == flc_pkg::ST_TORCH);
  assign flash_next   = (state_next == flc_pkg::ST_FLASH) && !supply_trip;
  assign torch_next   = (state_next == flc_pkg::ST_TORCH)
                        || ((state_next == flc_pkg::ST_FLASH) && supply_trip);
  assign powered_next = enabled && !therm_trip && (state_next != flc_pkg::ST_SHUTDOWN);

  // Sequencer state, drive outputs and read data.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg     <= flc_pkg::ST_IDLE;
      flash_req_reg <= 1'b0;
      channel_a_on  <= 1'b0;
      channel_b_on  <= 1'b0;
      flash_drive   <= 1'b0;
      torch_drive   <= 1'b0;
      core_powered  <= 1'b0;
      reg_rdata     <= '0;
    end else begin
      state_reg     <= state_next;
      flash_req_reg <= flash_req;
      channel_a_on  <= lit_next && ctl_reg[flc_pkg::ENABLE_OFF][flc_pkg::ENA_A_BIT];
      channel_b_on  <= lit_next && ctl_reg[flc_pkg::ENABLE_OFF][flc_pkg::ENA_B_BIT];
      flash_drive   <= flash_next;
      torch_drive   <= torch_next;
      core_powered  <= powered_next;
      if (reg_rd_en) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // Analogue settings are registered copies so they change cleanly after a write.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bank_unlocked             <= 1'b0;
      headroom_select           <= 1'b0;
      flash_level_code          <=
        flc_pkg::REG_RESET[flc_pkg::LEVEL_OFF][flc_pkg::FLEVEL_LSB +: flc_pkg::LEVEL_W];
      torch_level_code          <=
        flc_pkg::REG_RESET[flc_pkg::LEVEL_OFF][flc_pkg::TLEVEL_LSB +: flc_pkg::LEVEL_W];
      low_torch_scale           <= 1'b0;
      coil_limit_code           <=
        flc_pkg::REG_RESET[flc_pkg::PROT_OFF][flc_pkg::LIMIT_LSB +: flc_pkg::LIMIT_W];
      thermistor_threshold_code <= '0;
      supply_threshold_code     <= '0;
    end else begin
      bank_unlocked             <= unlocked;
      headroom_select           <= ctl_reg[flc_pkg::TIMING_OFF][flc_pkg::HEADROOM_BIT];
      flash_level_code          <=
        ctl_reg[flc_pkg::LEVEL_OFF][flc_pkg::FLEVEL_LSB +: flc_pkg::LEVEL_W];
      torch_level_code          <=
        ctl_reg[flc_pkg::LEVEL_OFF][flc_pkg::TLEVEL_LSB +: flc_pkg::LEVEL_W];
      low_torch_scale           <= ctl_reg[flc_pkg::LEVEL_OFF][flc_pkg::DIM_BIT];
      coil_limit_code           <=
        ctl_reg[flc_pkg::PROT_OFF][flc_pkg::LIMIT_LSB +: flc_pkg::LIMIT_W];
      thermistor_threshold_code <=
        ctl_reg[flc_pkg::PROT_OFF][flc_pkg::THERM_LSB +: flc_pkg::THERM_W];
      supply_threshold_code     <=
        ctl_reg[flc_pkg::PROT_OFF][flc_pkg::SUPPLY_LSB +: flc_pkg::SUPPLY_W];
    end
  end

  locked_write_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!unlocked && reg_wr_en && reg_addr == flc_pkg::ENABLE_OFF)
    |=> $stable(ctl_reg[flc_pkg::ENABLE_OFF]))
    else $error("Enable register changed while the bank was locked.");

  key_unlock_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr_en && reg_addr == flc_pkg::KEY_OFF && reg_wdata == flc_pkg::UNLOCK_KEY)
    |=> unlocked ##1 bank_unlocked)
    else $error("Writing the key did not open the bank.");

  power_down_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !enabled |=> (!channel_a_on && !channel_b_on && !core_powered))
    else $error("Light or power present with both enables clear.");

  edge_hold_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == flc_pkg::ST_FLASH && edge_mode && !timer_expired && enabled
     && !overheat_s && !therm_trip) |=> state_reg == flc_pkg::ST_FLASH)
    else $error("Edge-controlled flash ended before the timer.");

  shutdown_hold_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == flc_pkg::ST_SHUTDOWN && !auto_recover && enabled)
    |=> state_reg == flc_pkg::ST_SHUTDOWN)
    else $error("Shutdown left without clearing the enables.");

  thermistor_off_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    therm_trip |=> (!core_powered && !flash_drive && !torch_drive))
    else $error("Thermistor trip did not power down.");

  supply_torch_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_next == flc_pkg::ST_FLASH && supply_trip) |=> (torch_drive && !flash_drive))
    else $error("Low supply did not turn flash into torch.");

  expiry_dark_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == flc_pkg::ST_FLASH && timer_expired)
    |=> (!flash_drive && !torch_drive) [*2])
    else $error("Light stayed on after the flash timer expired.");

  timer_rearm_a : assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(timer_run) |=> !timer_expired)
    else $error("Flash timer kept its expiry after the flash ended.");

  reset_default_a : assert property (
    @(posedge clk_sys)
    !rst_n |=> (!unlocked
                && ctl_reg[flc_pkg::ENABLE_OFF] == flc_pkg::REG_RESET[flc_pkg::ENABLE_OFF]
                && ctl_reg[flc_pkg::TIMING_OFF] == flc_pkg::REG_RESET[flc_pkg::TIMING_OFF]
                && ctl_reg[flc_pkg::LEVEL_OFF] == flc_pkg::REG_RESET[flc_pkg::LEVEL_OFF]
                && ctl_reg[flc_pkg::PROT_OFF] == flc_pkg::REG_RESET[flc_pkg::PROT_OFF]
                && ctl_reg[flc_pkg::LIGHT_OFF] == flc_pkg::REG_RESET[flc_pkg::LIGHT_OFF]))
    else $error("Registers not at defaults after reset.");

endmodule : flc_regs

`default_nettype wire

// ==== rtl/flc_pkg.sv ====
/*
  Shared constants of the flash LED control register bank: register indices,
  field positions, write masks, reset values, the unlock key and the flash
  duration table.
  Assumes a 100 MHz system clock and a 3-bit register index from the
  serial protocol engine.
*/
`default_nettype none

package flc_pkg;

  localparam int          ADDR_W = 3;
  localparam int          DATA_W = 8;
  localparam int          NUM_REGS = 6;

  // Register indices as seen on the register port.
  localparam logic [2:0]  KEY_OFF    = 3'h0;
  localparam logic [2:0]  ENABLE_OFF = 3'h1;
  localparam logic [2:0]  TIMING_OFF = 3'h2;
  localparam logic [2:0]  LEVEL_OFF  = 3'h3;
  localparam logic [2:0]  PROT_OFF   = 3'h4;
  localparam logic [2:0]  LIGHT_OFF  = 3'h5;

  // Value that opens the bank for writes and reads.
  localparam logic [7:0]  UNLOCK_KEY = 8'h69;

  // Writable bits per register; undefined bits are not stored and read as zero.
  localparam logic [7:0]  REG_MASK [NUM_REGS] = '{8'hFF, 8'h03, 8'h7F, 8'h7F, 8'h7F, 8'h03};
  localparam logic [7:0]  REG_RESET [NUM_REGS] = '{8'h00, 8'h00, 8'h07, 8'h0C, 8'h02, 8'h00};

  // Field positions.
  localparam int          ENA_A_BIT   = 0;
  localparam int          ENA_B_BIT   = 1;
  localparam int          TIME_LSB    = 0;
  localparam int          TIME_W      = 4;
  localparam int          EDGE_BIT    = 4;
  localparam int          HEADROOM_BIT = 5;
  localparam int          RECOVER_BIT = 6;
  localparam int          FLEVEL_LSB  = 0;
  localparam int          TLEVEL_LSB  = 3;
  localparam int          LEVEL_W     = 3;
  localparam int          DIM_BIT     = 6;
  localparam int          LIMIT_LSB   = 0;
  localparam int          LIMIT_W     = 2;
  localparam int          THERM_LSB   = 2;
  localparam int          THERM_W     = 3;
  localparam int          SUPPLY_LSB  = 5;
  localparam int          SUPPLY_W    = 2;
  localparam int          TORCH_BIT   = 0;
  localparam int          FLASH_BIT   = 1;

  // Flash on-time in milliseconds per duration code.
  localparam int          MS_W = 10;
  localparam logic [9:0]  FLASH_MS [16] = '{10'h005, 10'h00A, 10'h014, 10'h01E, 10'h028,
                                            10'h032, 10'h046, 10'h05A, 10'h078, 10'h096,
                                            10'h0C8, 10'h0FA, 10'h12C, 10'h190, 10'h258,
                                            10'h320};

  // Clock period and the cycles in one millisecond derived from it.
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          NS_PER_MS = 1000000;
  localparam int          CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int          PRESCALE_W = 17;

  // Light control states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TORCH,
    ST_FLASH,
    ST_SPENT,
    ST_SHUTDOWN
  } flc_state_e;

endpackage : flc_pkg

`default_nettype wire

// ==== rtl/flc_sync.sv ====
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`default_nettype none

module flc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : flc_sync

`default_nettype wire

// ==== rtl/flc_flash_timer.sv ====
/*
  Flash on-time timer. Counts whole milliseconds while run is high and
  raises expired once the coded duration has elapsed.
  Assumes run drops for at least one cycle between flashes; dropping it
  re-arms the timer.
*/
`default_nettype none

module flc_flash_timer #(
  parameter int CYCLES_PER_MS = flc_pkg::CYCLES_PER_MS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        run,
  input  wire logic [flc_pkg::TIME_W-1:0]  dur_code,
  output logic                             expired
);

  logic [flc_pkg::PRESCALE_W-1:0] tick_reg;
  logic [flc_pkg::MS_W-1:0]       ms_reg;
  logic                           ms_tick;
  logic                           at_limit;

  assign ms_tick  = (tick_reg == flc_pkg::PRESCALE_W'(CYCLES_PER_MS - 1));
  assign at_limit = (ms_reg >= flc_pkg::FLASH_MS[dur_code]);

  // Both counters clear whenever run is low, so each flash gets a full duration.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      tick_reg <= '0;
      ms_reg   <= '0;
      expired  <= 1'b0;
    end else begin
      tick_reg <= ms_tick ? '0 : tick_reg + 1'b1;
      if (ms_tick && !at_limit) begin
        ms_reg <= ms_reg + 1'b1;
      end
      expired <= at_limit;
    end
  end

endmodule : flc_flash_timer

`default_nettype wire

// ==== dv/flc_host.sv ====
/*
  Host model that masters the register port of the control bank.
  Assumes the bank samples strobes on the rising clock edge.
*/
`default_nettype none

module flc_host (
  input  wire logic       clk_sys,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [2:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus starts quiet.
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
  end

  // One byte per strobe; the indices past the last control register are never written.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    if (a > 3'h5) return;
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_wdata = ~d; // Released data does not keep its last value.
  endtask : wr

  // Read data is taken one edge after the strobe.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : flc_host

`default_nettype wire

// ==== dv/flash_led_control_registers_bench.sv ====
/*
  Self-checking bench of the flash LED control bank.
  Assumes the host model file is compiled first; timer scaled to 10 cycles per ms.
*/
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, m); end end

module flash_led_control_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys, rst_n, wr_en, rd_en, strobe_pin, torch_pin;
  logic       overheat_detect, thermistor_low, supply_low, ch_a, ch_b, fl_d, to_d;
  logic       core, unl, hdr, lts;
  logic [2:0] addr, flc, tlc, tc;
  logic [1:0] cl, sc;
  logic [7:0] wdata, rdata;
  logic [2:0] r_a [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [7:0] r_w [5] = '{8'hFF, 8'hF0, 8'hC5, 8'hE3, 8'hFC};
  logic [7:0] r_e [5] = '{8'h03, 8'h70, 8'h45, 8'h63, 8'h00};
  logic [7:0] rv  [6] = '{8'h69, 8'h00, 8'h07, 8'h0C, 8'h02, 8'h00};
  int         err_total, n_checks, n;

  flc_regs #(.CYCLES_PER_MS(10)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .strobe_pin(strobe_pin), .torch_pin(torch_pin),
    .overheat_detect(overheat_detect), .thermistor_low(thermistor_low),
    .supply_low(supply_low), .channel_a_on(ch_a), .channel_b_on(ch_b),
    .flash_drive(fl_d), .torch_drive(to_d), .core_powered(core), .bank_unlocked(unl),
    .headroom_select(hdr), .flash_level_code(flc), .torch_level_code(tlc),
    .low_torch_scale(lts), .coil_limit_code(cl), .thermistor_threshold_code(tc),
    .supply_threshold_code(sc));
  flc_host host (.clk_sys(clk_sys), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));

  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  task automatic settle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : settle

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    `CHK(v, e, "read value")
  endtask : rd_chk

  // Bounded wait for the flash drive, then counts its lit cycles.
  task automatic flash_len(output int c);
    int k;
    c = 0;
    k = 0;
    while (fl_d !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    while (fl_d === 1'b1 && c < 200) begin
      @(negedge clk_sys);
      c++;
    end
    if (k >= 20 || c >= 200) begin
      err_total++;
      wrap_up();
    end
  endtask : flash_len

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Main sequence; the bank is locked until the key is written.
  initial begin
    {clk_sys, rst_n, strobe_pin, torch_pin, overheat_detect} = 5'h00;
    {thermistor_low, supply_low, err_total, n_checks} = '0;
    settle(3);
    rst_n = 1'b1;
    `CHK({unl, flc, tlc, cl, core}, 10'h10C, "reset outputs")
    host.wr(3'h1, 8'h03);
    rd_chk(3'h1, 8'h00);
    host.wr(3'h0, 8'h69);
    settle(2);
    `CHK(unl, 1'b1, "unlock")
    for (int i = 0; i < 6; i++) rd_chk(i[2:0], rv[i]);
    for (int i = 0; i < 5; i++) begin
      host.wr(r_a[i], r_w[i]);
      rd_chk(r_a[i], r_e[i]);
    end
    `CHK({hdr, lts, tlc, flc, sc, tc, cl}, 15'h62E3, "setting outputs")
    host.wr(3'h5, 8'h02);
    flash_len(n);
    `CHK(n >= 50 && n <= 53, 1'b1, "edge flash length")
    settle(3);
    `CHK({fl_d, to_d}, 2'b00, "dark after expiry")
    host.wr(3'h5, 8'h00);
    host.wr(3'h5, 8'h02);
    flash_len(n);
    `CHK(n >= 50 && n <= 53, 1'b1, "second flash length")
    host.wr(3'h5, 8'h00);
    host.wr(3'h2, 8'h00);
    fork
      flash_len(n);
      begin
        strobe_pin = 1'b1;
        settle(22);
        strobe_pin = 1'b0;
      end
    join
    `CHK(n < 30, 1'b1, "level flash ends with request")
    supply_low = 1'b1;
    host.wr(3'h5, 8'h03);
    settle(6);
    `CHK({fl_d, to_d}, 2'b01, "low supply torch")
    supply_low = 1'b0;
    host.wr(3'h5, 8'h00);
    host.wr(3'h5, 8'h01);
    host.wr(3'h1, 8'h01);
    settle(3);
    `CHK({ch_a, ch_b, to_d}, 3'b101, "torch channel a")
    host.wr(3'h1, 8'h00);
    settle(3);
    `CHK({core, to_d}, 2'b00, "power down")
    host.wr(3'h1, 8'h01);
    overheat_detect = 1'b1;
    settle(6);
    `CHK(to_d, 1'b0, "overheat off")
    overheat_detect = 1'b0;
    settle(6);
    `CHK(to_d, 1'b0, "stays off")
    host.wr(3'h1, 8'h00);
    host.wr(3'h1, 8'h01);
    settle(3);
    `CHK(to_d, 1'b1, "recovered")
    // With auto recovery set, the light returns as soon as the overheat level drops.
    host.wr(3'h2, 8'h40);
    overheat_detect = 1'b1;
    settle(6);
    `CHK(to_d, 1'b0, "auto overheat off")
    overheat_detect = 1'b0;
    settle(6);
    `CHK(to_d, 1'b1, "auto recovered")
    // The torch pin alone must light the torch once the torch bit is clear.
    host.wr(3'h5, 8'h00);
    torch_pin = 1'b1;
    settle(4);
    `CHK(to_d, 1'b1, "torch pin")
    host.wr(3'h4, 8'h04);
    thermistor_low = 1'b1;
    settle(6);
    `CHK({core, to_d}, 2'b00, "thermistor trip")
    {thermistor_low, torch_pin} = 2'b00;
    host.wr(3'h0, 8'h12);
    rd_chk(3'h1, 8'h00);
    rst_n = 1'b0;
    settle(3);
    rst_n = 1'b1;
    settle(1);
    `CHK({unl, flc, tlc, cl}, 9'h086, "second reset")
    wrap_up();
  end
endmodule : flash_led_control_registers_bench

`default_nettype wire
